// [include/seq_pkg.sv]
// Constants shared by the display state sequencer.
// Assumes a single core clock domain and plain port control.
package seq_pkg;
    // Microprogram state numbers as printed (octal-style labels).
    localparam logic [11:0] ST_IDLE = 12'h000;
    localparam logic [11:0] ST_DISPLAY_TEST = 12'h340;
    localparam logic [11:0] ST_DISPLAY_CLEAR = 12'h341;
    localparam logic [11:0] ST_LOAD_RESULT = 12'h121;
    localparam logic [11:0] ST_DIGIT_A = 12'h440;
    localparam logic [11:0] ST_DIGIT_B = 12'h441;
    // Count-11 display mode selected by the display clock enable.
    localparam int DISPLAY_COUNT_MODE = 11;
    // Reset values of the counters.
    localparam logic [3:0] DPC_RESET = 4'h0;
    localparam logic [3:0] AUX_RESET = 4'h0;
    localparam logic [3:0] DATA_REG_CNT_RESET = 4'h0;
    // Digit-counting passes: first pass plus a repeat.
    localparam logic [1:0] DIGIT_PASSES = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DISP = 3'b001,
        S_CLEAR = 3'b011,
        S_LOAD = 3'b010,
        S_DIGA = 3'b110,
        S_DIGB = 3'b111
    } seq_state_e;
endpackage

// [rtl/display_state_sequencer.sv]
// Display-test and result-load state sequencer of a counter processor.
// Assumes all inputs are synchronous to i_core_clk except the service
// switch, which is synchronised here.
//
// Summary of operation
// - Enabled service breakpoint switch forces a branch to display-test state 340.
// - Breakpoint shows doubled time count for frequency, else channel A events.
// - State 340 copies the data RAM entry at the display position counter to display, display clock enable, count-11.
// - State 340 decrements display position counter and also sets display clock enable.
// - State 340 asserts plug-in transmit inhibit, keeping bus free of plug-in data.
// - State 340 increments auxiliary test counter once, to exercise it.
// - State 341 clears auxiliary test counter and data register counter.
// - Counters used while driving the display return to reset after use.
// - State 121 after divide sets flag high and loads result register.
// - After arithmetic, digit-counting states 440 to 441 run a second time.
`timescale 1ns/1ps
module display_state_sequencer #(
    parameter int DATA_W = 4,
    parameter int RAM_DEPTH = 16,
    parameter int RESULT_W = 32,
    parameter int TIME_W = 32
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_service_breakpoint_two,
    input wire logic i_freq_mode,
    input wire logic [TIME_W-1:0] i_time_count,
    input wire logic [TIME_W-1:0] i_chan_a_events,
    input wire logic i_divide_done,
    input wire logic [RESULT_W-1:0] i_divide_result,
    input wire logic i_arith_done,
    input wire logic i_ram_we,
    input wire logic [$clog2(RAM_DEPTH)-1:0] i_ram_waddr,
    input wire logic [DATA_W-1:0] i_ram_wdata,
    output logic [11:0] o_state_num,
    output logic [DATA_W-1:0] o_display_data,
    output logic o_display_clock_enable,
    output logic o_count11_mode,
    output logic o_plugin_transmit_inhibit,
    output logic [3:0] o_display_position_counter,
    output logic [3:0] o_aux_test_counter,
    output logic [3:0] o_data_register_counter,
    output logic [TIME_W-1:0] o_service_value,
    output logic o_flag,
    output logic [RESULT_W-1:0] o_result_register,
    output logic [1:0] o_digit_pass
);
    localparam int AW = $clog2(RAM_DEPTH);

    typedef struct packed {
        logic bp_s1;
        logic bp_s2;
        seq_pkg::seq_state_e st;
        logic [DATA_W-1:0] disp;
        logic dce;
        logic inhibit;
        logic [3:0] dpc;
        logic [3:0] aux;
        logic [3:0] dreg_cnt;
        logic [TIME_W-1:0] svc;
        logic flag;
        logic [RESULT_W-1:0] result;
        logic [1:0] pass;
    } state_s;

    state_s q;
    state_s d;
    logic [DATA_W-1:0] ram_q [RAM_DEPTH];

    // Data RAM storage, written by the processor, read by the display.
    always_ff @(posedge i_core_clk)
    begin
        if (i_ce && i_ram_we)
        begin
            ram_q[i_ram_waddr] <= i_ram_wdata;
        end
    end

    function automatic logic [11:0] state_number(seq_pkg::seq_state_e s);
        case (s)
            seq_pkg::S_DISP: state_number = seq_pkg::ST_DISPLAY_TEST;
            seq_pkg::S_CLEAR: state_number = seq_pkg::ST_DISPLAY_CLEAR;
            seq_pkg::S_LOAD: state_number = seq_pkg::ST_LOAD_RESULT;
            seq_pkg::S_DIGA: state_number = seq_pkg::ST_DIGIT_A;
            seq_pkg::S_DIGB: state_number = seq_pkg::ST_DIGIT_B;
            default: state_number = seq_pkg::ST_IDLE;
        endcase
    endfunction

    always_comb
    begin
        d = q;
        d.bp_s1 = i_service_breakpoint_two;
        d.bp_s2 = q.bp_s1;
        d.dce = 1'b0;
        d.inhibit = 1'b0;
        // Service value follows the measurement function under breakpoint.
        if (q.bp_s2)
        begin
            if (i_freq_mode)
            begin
                d.svc = {i_time_count[TIME_W-2:0], 1'b0};
            end
            else
            begin
                d.svc = i_chan_a_events;
            end
        end
        case (q.st)
            seq_pkg::S_IDLE:
            begin
                if (q.bp_s2)
                begin
                    d.st = seq_pkg::S_DISP;
                end
                else if (i_divide_done)
                begin
                    d.st = seq_pkg::S_LOAD;
                end
                else if (i_arith_done)
                begin
                    d.pass = 2'h0;
                    d.st = seq_pkg::S_DIGA;
                end
            end
            seq_pkg::S_DISP:
            begin
                d.disp = ram_q[q.dpc[AW-1:0]];
                d.dce = 1'b1;
                d.dpc = q.dpc - 4'h1;
                d.inhibit = 1'b1;
                d.aux = q.aux + 4'h1;
                d.st = seq_pkg::S_CLEAR;
            end
            seq_pkg::S_CLEAR:
            begin
                d.aux = seq_pkg::AUX_RESET;
                d.dreg_cnt = seq_pkg::DATA_REG_CNT_RESET;
                d.dpc = seq_pkg::DPC_RESET;
                d.st = seq_pkg::S_IDLE;
            end
            seq_pkg::S_LOAD:
            begin
                d.flag = 1'b1;
                d.result = i_divide_result;
                d.st = seq_pkg::S_IDLE;
            end
            seq_pkg::S_DIGA:
            begin
                d.dreg_cnt = q.dreg_cnt + 4'h1;
                d.st = seq_pkg::S_DIGB;
            end
            seq_pkg::S_DIGB:
            begin
                d.pass = q.pass + 2'h1;
                // Second pass of 440..441 after arithmetic.
                if (q.pass + 2'h1 < seq_pkg::DIGIT_PASSES)
                begin
                    d.st = seq_pkg::S_DIGA;
                end
                else
                begin
                    d.dreg_cnt = seq_pkg::DATA_REG_CNT_RESET;
                    d.st = seq_pkg::S_IDLE;
                end
            end
            default:
            begin
                d.st = seq_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
            q.st <= seq_pkg::S_IDLE;
            q.dpc <= seq_pkg::DPC_RESET;
            q.aux <= seq_pkg::AUX_RESET;
            q.dreg_cnt <= seq_pkg::DATA_REG_CNT_RESET;
        end
        else if (i_ce)
        begin
            q <= d;
        end
    end

    assign o_state_num = state_number(q.st);
    assign o_display_data = q.disp;
    assign o_display_clock_enable = q.dce;
    assign o_count11_mode = q.dce;
    assign o_plugin_transmit_inhibit = q.inhibit;
    assign o_display_position_counter = q.dpc;
    assign o_aux_test_counter = q.aux;
    assign o_data_register_counter = q.dreg_cnt;
    assign o_service_value = q.svc;
    assign o_flag = q.flag;
    assign o_result_register = q.result;
    assign o_digit_pass = q.pass;
endmodule // display_state_sequencer

// [verification/display_panel_model.sv]
// Front panel model: counts digits strobed out to the display.
// Assumes it watches the sequencer outputs on the core clock.
`timescale 1ns/1ps
module display_panel_model (
    input logic i_core_clk,
    input logic i_dce,
    input logic i_inhibit,
    output int o_strobes
);
    initial o_strobes = 0;
    // A digit is taken only while plug-in traffic is held off the bus.
    always @(posedge i_core_clk)
        if (i_dce && i_inhibit)
            o_strobes <= o_strobes + 1;
endmodule // display_panel_model

// [verification/display_state_sequencer_assertions.sv]
// Checker for the display state sequencer.
// Assumes i_ce stays high and is bound to the display state sequencer module.
`timescale 1ns/1ps
module display_state_sequencer_assertions #(
    parameter int RESULT_W = 32
) (
    input logic i_core_clk,
    input logic i_rst_n,
    input logic [RESULT_W-1:0] i_divide_result,
    input logic i_arith_done,
    input logic [11:0] o_state_num,
    input logic o_display_clock_enable,
    input logic o_plugin_transmit_inhibit,
    input logic [3:0] o_display_position_counter,
    input logic [3:0] o_aux_test_counter,
    input logic [3:0] o_data_register_counter,
    input logic o_flag,
    input logic [RESULT_W-1:0] o_result_register
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence dig_pass;
        o_state_num == 12'h440 ##1 o_state_num == 12'h441;
    endsequence
    test_step_a: assert property (o_state_num == 12'h340 |=>
        o_state_num == 12'h341 && o_display_clock_enable)
        else $error("no display step");
    clk_pulse_a: assert property (o_display_clock_enable |=>
        !o_display_clock_enable) else $error("long strobe");
    bus_inhibit_a: assert property (o_display_clock_enable |->
        o_plugin_transmit_inhibit) else $error("bus not held");
    pos_dec_a: assert property (o_state_num == 12'h340 |=>
        o_display_position_counter ==
        $past(o_display_position_counter) - 4'h1) else $error("pos");
    aux_inc_a: assert property (o_state_num == 12'h340 |=>
        o_aux_test_counter == $past(o_aux_test_counter) + 4'h1)
        else $error("aux count");
    count_clear_a: assert property (o_state_num == 12'h341 |=>
        {o_aux_test_counter, o_data_register_counter,
        o_display_position_counter} == 12'h0) else $error("no clear");
    result_load_a: assert property (o_state_num == 12'h121 |=>
        o_flag && o_result_register == $past(i_divide_result))
        else $error("result not loaded");
    digit_repeat_a: assert property (i_arith_done &&
        o_state_num == 12'h0 |=> dig_pass ##1 dig_pass ##1
        o_state_num == 12'h0) else $error("digit passes");
endmodule // display_state_sequencer_assertions
bind display_state_sequencer display_state_sequencer_assertions #(
    .RESULT_W(RESULT_W)) i_display_state_sequencer_assertions (.*);

// [verification/display_state_sequencer_tb_top.sv]
// Self-checking bench for the display state sequencer.
// Assumes the bound checker and the panel model watch the outputs.
`timescale 1ns/1ps
module display_state_sequencer_tb_top;
    logic i_core_clk = 0, i_rst_n = 0, i_ce = 1, i_ram_we = 0;
    logic i_service_breakpoint_two = 0, i_freq_mode = 0;
    logic i_divide_done = 0, i_arith_done = 0, o_flag;
    logic [31:0] i_time_count = 32'h4321, i_chan_a_events = 32'ha7;
    logic [31:0] i_divide_result = 0, o_service_value, o_result_register;
    logic [3:0] i_ram_waddr = 0, i_ram_wdata = 4'h5, o_display_data;
    logic [3:0] o_display_position_counter, o_aux_test_counter;
    logic [3:0] o_data_register_counter;
    logic [11:0] o_state_num;
    logic o_display_clock_enable, o_count11_mode, o_plugin_transmit_inhibit;
    logic [1:0] o_digit_pass;
    int miscompares = 0, cmp_count = 0, strobes;
    always #2.5 i_core_clk = ~i_core_clk;
    display_state_sequencer i_display_state_sequencer (.*);
    display_panel_model i_display_panel_model (.i_core_clk,
        .i_dce(o_display_clock_enable),
        .i_inhibit(o_plugin_transmit_inhibit), .o_strobes(strobes));
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic wait_state(logic [11:0] s);
        #1;
        for (int i = 0; i < 20 && o_state_num !== s; i++)
            step(1);
        chk(o_state_num, s);
        if (o_state_num !== s)
            report_and_stop();
    endtask
    task automatic t_display(logic fm, logic [31:0] exp);
        @(posedge i_core_clk)
        begin
            i_freq_mode <= fm;
            i_service_breakpoint_two <= 1;
        end
        @(posedge i_core_clk) i_service_breakpoint_two <= 0;
        wait_state(12'h340);
        chk(o_service_value, exp);
        step(1);
        chk({o_state_num, o_display_clock_enable, o_count11_mode,
            o_plugin_transmit_inhibit, o_display_position_counter,
            o_aux_test_counter, o_display_data}, 27'h1a0_ff15);
        step(1);
        chk({o_state_num, o_aux_test_counter, o_data_register_counter,
            o_display_position_counter}, 0);
    endtask
    task automatic t_divide();
        @(posedge i_core_clk)
        begin
            i_divide_result <= 32'h1357_9bdf;
            i_divide_done <= 1;
        end
        @(posedge i_core_clk) i_divide_done <= 0;
        wait_state(12'h121);
        step(1);
        chk({o_flag, o_result_register}, 33'h1_1357_9bdf);
    endtask
    task automatic t_digits();
        @(posedge i_core_clk) i_arith_done <= 1;
        @(posedge i_core_clk) i_arith_done <= 0;
        wait_state(12'h440);
        for (int k = 0; k < 4; k++)
        begin
            chk(o_state_num, k[0] ? 12'h441 : 12'h440);
            step(1);
        end
        chk({o_state_num, o_digit_pass, o_data_register_counter},
            18'h00020);
    endtask
    initial
    begin
        step(20);
        @(posedge i_core_clk) i_rst_n <= 1;
        step(1);
        chk({o_state_num, o_flag, o_result_register}, 0);
        i_ram_we <= 1;
        for (int a = 0; a < 16; a++)
            @(posedge i_core_clk) i_ram_waddr <= a[3:0];
        @(posedge i_core_clk) i_ram_we <= 0;
        t_display(1, 32'h8642);
        t_display(0, 32'ha7);
        chk(strobes, 2);
        t_divide();
        t_digits();
        report_and_stop();
    end
endmodule // display_state_sequencer_tb_top
